// File: verilog/pac_adc_ctrl.sv
// Output control of a 12-bit pipelined sampling converter
// Behaviour
// - Sample taken on rising clock edge
// - Code appears six cycles after sample when not stalled: five pipeline stages, buffer, output register
// - Normal mode: convert and drive outputs
// - Output disabled: convert, outputs high impedance
// - Nap: outputs high impedance
// - Sleep: stops converting the same way as nap, outputs high impedance
// - Format pin picks format and stabilizer
// - Overflow flag marks out-of-range samples
// - Twelve-bit code, top bit is MSB
module pac_adc_ctrl #(
    parameter int CODE_W = pac_pkg::CODE_W,
    parameter int LATENCY = pac_pkg::LATENCY
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [CODE_W-1:0] analog_code,
    input wire logic analog_over,
    input wire logic analog_under,
    input wire logic power_down_select,
    input wire logic out_drive_en_n,
    input wire logic [1:0] format_select,
    output logic [CODE_W-1:0] sample_code_bus,
    output logic sample_code_oe,
    output logic range_overflow_flag,
    output logic range_overflow_oe,
    output logic stabilizer_on,
    output logic converting,
    output logic sample_valid,
    input wire logic sample_ready
);
    localparam int BW = CODE_W + 1;

    typedef struct packed {
        logic [2:0] pd_sync;
        logic [2:0] oe_sync;
        logic [1:0] fmt_s0;
        logic [1:0] fmt_s1;
        logic [1:0] fmt_s2;
        logic pd_q;
        logic oen_q;
        logic [1:0] fmt_q;
        logic [LATENCY-1:0] vld;
        logic [LATENCY-1:0][CODE_W:0] pipe;
        logic [CODE_W-1:0] code;
        logic flag;
        logic drive;
        logic stab;
        logic conv;
        logic valid;
    } pac_st_t;

    pac_st_t st_ff;
    pac_st_t nxt_st;
    pac_pkg::pac_mode_t mode;
    logic buf_in_ready;
    logic buf_out_valid;
    logic [BW-1:0] buf_out_data;
    logic take;

    function automatic pac_pkg::pac_mode_t pac_mode(input logic pd, input logic oen);
        unique case ({pd, oen})
            2'b00: pac_mode = pac_pkg::PAC_NORMAL;
            2'b01: pac_mode = pac_pkg::PAC_OUT_HIZ;
            2'b10: pac_mode = pac_pkg::PAC_NAP;
            2'b11: pac_mode = pac_pkg::PAC_SLEEP;
        endcase
    endfunction : pac_mode

    assign mode = pac_mode(st_ff.pd_q, st_ff.oen_q);
    assign take = st_ff.valid && sample_ready;

    pac_skid #(.W(BW)) u_buf (
        .clk(clk),
        .reset(reset),
        .in_valid(st_ff.vld[LATENCY-1]),
        .in_ready(buf_in_ready),
        .in_data(st_ff.pipe[LATENCY-1]),
        .out_valid(buf_out_valid),
        .out_ready(!st_ff.valid || take),
        .out_data(buf_out_data)
    );

    always_comb begin
        nxt_st = st_ff;
        nxt_st.pd_sync = {st_ff.pd_sync[1:0], power_down_select};
        nxt_st.oe_sync = {st_ff.oe_sync[1:0], out_drive_en_n};
        nxt_st.fmt_s0 = format_select;
        nxt_st.fmt_s1 = st_ff.fmt_s0;
        nxt_st.fmt_s2 = st_ff.fmt_s1;
        if (st_ff.pd_sync[1] == st_ff.pd_sync[2]) begin
            nxt_st.pd_q = st_ff.pd_sync[2];
        end
        if (st_ff.oe_sync[1] == st_ff.oe_sync[2]) begin
            nxt_st.oen_q = st_ff.oe_sync[2];
        end
        if (st_ff.fmt_s1 == st_ff.fmt_s2) begin
            nxt_st.fmt_q = st_ff.fmt_s2;
        end
        // Converting in normal and output-disabled modes
        nxt_st.conv = (mode == pac_pkg::PAC_NORMAL) || (mode == pac_pkg::PAC_OUT_HIZ);
        // Stabilizer on at the two middle levels
        nxt_st.stab = (st_ff.fmt_q == pac_pkg::FMT_THIRD)
            || (st_ff.fmt_q == pac_pkg::FMT_TWO_THIRDS);
        // Whole pipeline waits while the buffer is full, so no word in flight is lost
        if (buf_in_ready) begin
            // Capture one sample each rising edge the buffer has room, marked valid only while converting
            nxt_st.pipe[0][CODE_W-1:0] = analog_code;
            // Flag on over or under range
            nxt_st.pipe[0][CODE_W] = analog_over || analog_under;
            nxt_st.vld[0] = st_ff.conv;
            for (int i = 1; i < LATENCY; i++) begin
                nxt_st.pipe[i] = st_ff.pipe[i-1];
                nxt_st.vld[i] = st_ff.vld[i-1] && st_ff.conv;
            end
        end
        // Nap or sleep drops whatever is in flight
        if (!st_ff.conv) begin
            nxt_st.vld = '0;
        end
        if (buf_out_valid && (!st_ff.valid || take)) begin
            if (st_ff.fmt_q[1]) begin
                nxt_st.code = buf_out_data[CODE_W-1:0] ^ pac_pkg::CODE_MSB_MASK;
            end else begin
                nxt_st.code = buf_out_data[CODE_W-1:0];
            end
            nxt_st.flag = buf_out_data[CODE_W];
            nxt_st.valid = 1'b1;
        end else if (take) begin
            nxt_st.valid = 1'b0;
        end
        // Only normal mode drives the pins
        nxt_st.drive = (mode == pac_pkg::PAC_NORMAL);
        if (!st_ff.conv) begin
            nxt_st.valid = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Code bit CODE_W-1 is the MSB
    assign sample_code_bus = st_ff.code;
    assign range_overflow_flag = st_ff.flag;
    assign sample_code_oe = st_ff.drive;
    assign range_overflow_oe = st_ff.drive;
    assign stabilizer_on = st_ff.stab;
    assign converting = st_ff.conv;
    assign sample_valid = st_ff.valid;

    property p_hiz_out;
        @(posedge clk) disable iff (reset)
        $past(mode) != pac_pkg::PAC_NORMAL |-> !sample_code_oe;
    endproperty
    a_hiz_out: assert property (p_hiz_out) else $error("outputs driven outside normal");
    property p_drive;
        @(posedge clk) disable iff (reset)
        mode == pac_pkg::PAC_NORMAL |=> sample_code_oe && range_overflow_oe;
    endproperty
    a_drive: assert property (p_drive) else $error("normal mode not driving");
    property p_conv;
        @(posedge clk) disable iff (reset)
        mode == pac_pkg::PAC_OUT_HIZ |=> converting;
    endproperty
    a_conv: assert property (p_conv) else $error("output-off mode stopped");
    property p_sleep;
        @(posedge clk) disable iff (reset)
        mode == pac_pkg::PAC_SLEEP |=> !converting ##1 !sample_valid;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep still converting");
    property p_stab;
        @(posedge clk) disable iff (reset)
        st_ff.fmt_q == pac_pkg::FMT_FULL |=> !stabilizer_on;
    endproperty
    a_stab: assert property (p_stab) else $error("stabilizer on at full level");
    sequence s_sampled;
        st_ff.conv && buf_in_ready && $stable(st_ff.conv);
    endsequence
    property p_latency;
        @(posedge clk) disable iff (reset)
        s_sampled ##1 (st_ff.conv && buf_in_ready)[*4] |=> st_ff.vld[LATENCY-1];
    endproperty
    a_latency: assert property (p_latency) else $error("latency not five");
    property p_flag;
        @(posedge clk) disable iff (reset)
        (analog_over || analog_under) && buf_in_ready |=> st_ff.pipe[0][CODE_W];
    endproperty
    a_flag: assert property (p_flag) else $error("overflow not captured");
    property p_hold;
        @(posedge clk) disable iff (reset)
        sample_valid && !sample_ready && converting |=> $stable(sample_code_bus);
    endproperty
    a_hold: assert property (p_hold) else $error("code changed while stalled");
endmodule : pac_adc_ctrl

// File: verilog/pac_pkg.sv
// Constants and types for the pipelined converter output control block
package pac_pkg;
    localparam int CODE_W = 12;
    localparam int LATENCY = 5;
    localparam logic [CODE_W-1:0] CODE_MSB_MASK = 12'h0800;
    localparam logic [CODE_W-1:0] CODE_ZERO = 12'h0000;
    localparam logic [CODE_W-1:0] CODE_FULL = 12'h0FFF;
    // Format pin levels: ground, one third, two thirds, full supply
    localparam logic [1:0] FMT_GND = 2'h0;
    localparam logic [1:0] FMT_THIRD = 2'h1;
    localparam logic [1:0] FMT_TWO_THIRDS = 2'h2;
    localparam logic [1:0] FMT_FULL = 2'h3;
    typedef enum logic [1:0] {
        PAC_NORMAL,
        PAC_OUT_HIZ,
        PAC_NAP,
        PAC_SLEEP
    } pac_mode_t;
endpackage : pac_pkg

// File: verilog/pac_skid.sv
// Two-entry buffer with valid/ready on both sides
module pac_skid #(
    parameter int W = 13
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    typedef struct packed {
        logic [1:0] cnt;
        logic [W-1:0] e0;
        logic [W-1:0] e1;
    } pac_skid_st_t;
    pac_skid_st_t st_ff;
    pac_skid_st_t nxt_st;
    logic push;
    logic pop;

    assign in_ready = (st_ff.cnt != 2'h2);
    assign out_valid = (st_ff.cnt != 2'h0);
    assign out_data = st_ff.e0;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        nxt_st = st_ff;
        if (pop) begin
            nxt_st.e0 = st_ff.e1;
        end
        if (push) begin
            if ((st_ff.cnt == 2'h0) || (pop && st_ff.cnt == 2'h1)) begin
                nxt_st.e0 = in_data;
            end else if (pop) begin
                nxt_st.e1 = in_data;
            end else if (st_ff.cnt == 2'h1) begin
                nxt_st.e1 = in_data;
            end
        end
        nxt_st.cnt = st_ff.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule : pac_skid

// File: bench/pac_capture.sv
// Capture logic model that takes the parallel result codes
module pac_capture (
    input wire logic clk,
    input wire logic reset,
    input wire logic stall,
    input wire logic [1:0] fmt,
    input wire logic sample_valid,
    input wire logic [11:0] sample_code_bus,
    input wire logic range_overflow_flag,
    output logic sample_ready,
    output logic got,
    output logic [11:0] got_code,
    output logic got_flag
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] slot_ff = 2'h0;
    initial begin
        sample_ready = 1'b0;
        got = 1'b0;
    end
    // Stalling keeps ready high one cycle in four
    always @(negedge clk) begin
        slot_ff <= slot_ff + 2'h1;
        sample_ready <= !reset && (!stall || slot_ff == 2'h3);
    end
    always @(posedge clk) begin
        got <= sample_valid && sample_ready && !reset;
        if (sample_valid && sample_ready) begin
            got_code <= sample_code_bus ^ (fmt[1] ? pac_pkg::CODE_MSB_MASK : 12'h000);
            got_flag <= range_overflow_flag;
        end
    end
endmodule : pac_capture

// File: bench/pac_adc_ctrl_tb.sv
// Testbench for the converter output control block
module pac_adc_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, reset = 1, pd = 0, oe_n = 0, stall = 0, chk = 0;
    logic [1:0] fmt = 2'h0;
    logic [11:0] code = 12'h000, last = 12'h000, hold_code;
    logic [15:0] cyc = 16'h0000;
    logic [11:0] bus, got_code;
    logic bus_oe, flag, flag_oe, stab, conv, valid, ready, got, got_flag, hold = 0;
    int fail_count = 0, checks_done = 0, n_got = 0;
    pac_adc_ctrl i_pac_adc_ctrl (.clk(clk), .reset(reset), .analog_code(code),
        .analog_over(code[3:0] == 4'hF), .analog_under(code[3:0] == 4'h0),
        .power_down_select(pd), .out_drive_en_n(oe_n), .format_select(fmt),
        .sample_code_bus(bus), .sample_code_oe(bus_oe), .range_overflow_flag(flag),
        .range_overflow_oe(flag_oe), .stabilizer_on(stab), .converting(conv),
        .sample_valid(valid), .sample_ready(ready));
    pac_capture i_pac_capture (.clk(clk), .reset(reset), .stall(stall), .fmt(fmt),
        .sample_valid(valid), .sample_code_bus(bus), .range_overflow_flag(flag),
        .sample_ready(ready), .got(got), .got_code(got_code), .got_flag(got_flag));
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run
    always @(posedge clk) begin
        cyc <= cyc + 16'h0001;
        if (cyc == 16'd3000) begin
            fail_count++;
            complete_run();
        end
        if (chk && hold) begin
            check({valid, bus}, {1'b1, hold_code}, "held");
        end
        hold <= valid && !ready;
        hold_code <= bus;
    end
    always @(negedge clk) begin
        code <= cyc[11:0];
        if (chk && got) begin
            n_got++;
            check(got_flag, got_code[3:0] == 4'hF || got_code[3:0] == 4'h0, "flag");
            if (!stall) begin
                // Pipeline, buffer, output register, capture edge, code set one edge early
                check(cyc[11:0] - got_code, pac_pkg::LATENCY + 3, "latency");
            end
            check(got_code > last, 1'b1, "order");
            last <= got_code;
        end
    end
    task automatic t_format();
        for (int f = 0; f < 4; f++) begin
            fmt = f[1:0];
            repeat (20) @(negedge clk);
            check(stab, f == 1 || f == 2, "stabilizer");
            check({bus_oe, flag_oe, conv}, 3'h7, "normal");
            n_got = 0;
            chk = 1;
            repeat (40) @(negedge clk);
            chk = 0;
            check(n_got > 30, 1'b1, "stream");
        end
        $display("test format done");
    endtask : t_format
    task automatic t_stall();
        stall = 1;
        chk = 1;
        n_got = 0;
        repeat (60) @(negedge clk);
        chk = 0;
        stall = 0;
        check(n_got > 5, 1'b1, "stalled stream");
        $display("test stall done");
    endtask : t_stall
    task automatic t_modes();
        logic [1:0] pins [3] = '{2'h1, 2'h2, 2'h3};
        for (int i = 0; i < 3; i++) begin
            {pd, oe_n} = pins[i];
            repeat (25) @(negedge clk);
            check({bus_oe, flag_oe}, 2'h0, "hiz");
            check(conv, i == 0, "converting");
            if (i > 0) begin
                check(valid, 1'b0, "no samples");
            end
        end
        {pd, oe_n} = 2'h0;
        repeat (25) @(negedge clk);
        check({bus_oe, conv}, 2'h3, "back to normal");
        $display("test modes done");
    endtask : t_modes
    task automatic t_reset();
        reset = 1;
        repeat (2) @(negedge clk);
        check({valid, bus_oe, conv}, 3'h0, "in reset");
        reset = 0;
        repeat (25) @(negedge clk);
        check(conv, 1'b1, "after reset");
        $display("test reset done");
    endtask : t_reset
    initial begin
        repeat (20) @(negedge clk);
        reset = 0;
        t_format();
        t_stall();
        t_modes();
        t_reset();
        complete_run();
    end
endmodule : pac_adc_ctrl_tb
